// >>> rtl/adc_ctrl_pkg.sv
// Shared constants, register map and types for the converter control block.
package adc_ctrl_pkg;

  // ****************************************************************
  // Geometry of results and register bus
  // ****************************************************************
  localparam int RESULT_WIDTH  = 10;
  localparam int RESULT_SHIFT  = 6;
  localparam int RESULT_COUNT  = 4;
  localparam int BUS_WIDTH     = 8;
  localparam int ADDR_WIDTH    = 4;
  localparam int CHANNEL_WIDTH = 4;

  // ****************************************************************
  // Register offsets on the byte bus
  // ****************************************************************
  // Result n upper byte at 2n, lower byte at 2n+1.
  localparam logic [3:0] OFS_RESULT_BASE    = 4'h0;
  localparam logic [3:0] OFS_RESULT_LAST    = 4'h7;
  localparam logic [3:0] OFS_CONTROL_STATUS = 4'h8;
  localparam logic [3:0] OFS_CONTROL        = 4'h9;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT_END_FLAG    = 7;
  localparam int BIT_IRQ_ENABLE  = 6;
  localparam int BIT_START       = 5;
  localparam int BIT_SCAN        = 4;
  localparam int BIT_SET_SELECT  = 3;
  localparam int BIT_GROUP_SEL   = 2;
  localparam int BIT_INDEX_HI    = 1;
  localparam int BIT_INDEX_LO    = 0;
  localparam int BIT_MODULE_STOP = 7;
  localparam int BIT_TIMER_EN    = 1;
  localparam int BIT_EXT_EN      = 0;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] CONTROL_STATUS_RESET = 8'h00;
  localparam logic [7:0] CONTROL_RESET        = 8'h00;
  localparam logic [9:0] RESULT_RESET         = 10'h000;

  // ****************************************************************
  // Timing of the approximation engine
  // ****************************************************************
  localparam int CLK_PERIOD_NS  = 100;
  localparam int SAMPLE_TIME_NS = 1000;
  localparam int BIT_TIME_NS    = 200;
  localparam int SAMPLE_CYCLES  = (SAMPLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BIT_CYCLES     = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // State types
  // ****************************************************************
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_LAUNCH, SEQ_RUN} seq_state_type;
  typedef enum logic [1:0] {SAR_IDLE, SAR_SAMPLE, SAR_BITS} sar_state_type;

endpackage : adc_ctrl_pkg

// >>> rtl/sar_engine.sv
// Successive approximation engine: sample phase, then one trial per bit.
`timescale 1ns/1ns
`default_nettype none
module sar_engine
  import adc_ctrl_pkg::*;
#(
  parameter int WIDTH         = adc_ctrl_pkg::RESULT_WIDTH,
  parameter int SAMPLE_CYCLES = adc_ctrl_pkg::SAMPLE_CYCLES,
  parameter int BIT_CYCLES    = adc_ctrl_pkg::BIT_CYCLES
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             start,
  input  wire logic             abort,
  input  wire logic             comparator_high,
  output var  logic             sample_hold,
  output var  logic [WIDTH-1:0] dac_code,
  output var  logic             done,
  output var  logic [WIDTH-1:0] result
);

  sar_state_type    state_ff, nxt_state;
  logic [7:0]       cnt_ff, nxt_cnt;
  logic [3:0]       bit_ff, nxt_bit;
  logic [WIDTH-1:0] code_ff, nxt_code;
  logic             hold_ff, nxt_hold;
  logic             done_ff, nxt_done;

  // Next state: hold the input, then keep or drop each trial bit from MSB down.
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_bit   = bit_ff;
    nxt_code  = code_ff;
    nxt_hold  = 1'b0;
    nxt_done  = 1'b0;
    case (state_ff)
      SAR_IDLE: begin
        if (start && !abort) begin
          nxt_state = SAR_SAMPLE;
          nxt_cnt   = 8'(SAMPLE_CYCLES - 1);
          nxt_hold  = 1'b1;
        end
      end
      SAR_SAMPLE: begin
        nxt_hold = 1'b1;
        if (cnt_ff != 8'h00) begin
          nxt_cnt = cnt_ff - 8'h01;
        end else begin
          nxt_hold  = 1'b0;
          nxt_state = SAR_BITS;
          nxt_bit   = 4'(WIDTH - 1);
          nxt_code  = {1'b1, {(WIDTH-1){1'b0}}};
          nxt_cnt   = 8'(BIT_CYCLES - 1);
        end
      end
      SAR_BITS: begin
        if (cnt_ff != 8'h00) begin
          nxt_cnt = cnt_ff - 8'h01;
        end else begin
          nxt_code[bit_ff] = comparator_high;
          nxt_cnt          = 8'(BIT_CYCLES - 1);
          if (bit_ff == 4'h0) begin
            nxt_state = SAR_IDLE;
            nxt_done  = 1'b1;
          end else begin
            nxt_bit                = bit_ff - 4'h1;
            nxt_code[bit_ff-4'h1]  = 1'b1;
          end
        end
      end
      default: nxt_state = SAR_IDLE;
    endcase
    if (abort) begin
      nxt_state = SAR_IDLE;
      nxt_hold  = 1'b0;
      nxt_done  = 1'b0;
    end
  end

  // Registers of the engine.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= SAR_IDLE;
      cnt_ff   <= 8'h00;
      bit_ff   <= 4'h0;
      code_ff  <= '0;
      hold_ff  <= 1'b0;
      done_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      bit_ff   <= nxt_bit;
      code_ff  <= nxt_code;
      hold_ff  <= nxt_hold;
      done_ff  <= nxt_done;
    end
  end

  assign sample_hold = hold_ff;
  assign dac_code    = code_ff;
  assign done        = done_ff;
  assign result      = code_ff;

endmodule : sar_engine
`default_nettype wire

// >>> rtl/adc_channel_result_control.sv
// Digital control of a sixteen-input converter with four byte-read result registers.
`timescale 1ns/1ns
`default_nettype none
module adc_channel_result_control
  import adc_ctrl_pkg::*;
#(
  parameter int SAMPLE_CYCLES = adc_ctrl_pkg::SAMPLE_CYCLES,
  parameter int BIT_CYCLES    = adc_ctrl_pkg::BIT_CYCLES
) (
  input  wire logic                                    clk,
  input  wire logic                                    rst_b,
  input  wire logic [adc_ctrl_pkg::ADDR_WIDTH-1:0]     bus_addr,
  input  wire logic [adc_ctrl_pkg::BUS_WIDTH-1:0]      bus_wdata,
  input  wire logic                                    bus_wr,
  input  wire logic                                    bus_rd,
  output var  logic [adc_ctrl_pkg::BUS_WIDTH-1:0]      bus_rdata,
  input  wire logic                                    timer_trigger,
  input  wire logic                                    external_trigger_pin_b,
  input  wire logic                                    comparator_high,
  output var  logic [adc_ctrl_pkg::CHANNEL_WIDTH-1:0]  analog_channel,
  output var  logic                                    sample_hold,
  output var  logic [adc_ctrl_pkg::RESULT_WIDTH-1:0]   dac_code,
  output var  logic                                    conversion_end_irq
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic                    end_flag_ff, nxt_end_flag;
  logic                    flag_seen_ff, nxt_flag_seen;
  logic                    irq_enable_ff, nxt_irq_enable;
  logic                    start_ff, nxt_start;
  logic                    scan_ff, nxt_scan;
  logic                    set_select_ff, nxt_set_select;
  logic                    group_select_ff, nxt_group_select;
  logic [1:0]              index_ff, nxt_index;
  logic                    module_stop_ff, nxt_module_stop;
  logic                    timer_en_ff, nxt_timer_en;
  logic                    ext_en_ff, nxt_ext_en;
  logic [7:0]              temp_ff, nxt_temp;
  logic [7:0]              rdata_ff, nxt_rdata;
  logic [RESULT_WIDTH-1:0] result_ff [RESULT_COUNT];
  logic [RESULT_WIDTH-1:0] nxt_result [RESULT_COUNT];
  seq_state_type           seq_ff, nxt_seq;
  logic [1:0]              cur_ff, nxt_cur;
  logic [3:0]              channel_ff, nxt_channel;
  logic                    eng_start_ff, nxt_eng_start;
  logic                    irq_ff, nxt_irq;
  logic                    ext_s1_ff, ext_s2_ff, ext_s3_ff;
  logic                    ext_level_ff, nxt_ext_level;
  logic                    ext_fall;
  logic                    eng_abort;
  logic                    eng_done;
  logic [RESULT_WIDTH-1:0] eng_result;
  logic                    seq_single_end;
  logic                    seq_pass_end;
  logic [7:0]              status_byte;
  logic [7:0]              control_byte;

  // ****************************************************************
  // Address decoding
  // ****************************************************************
  // Reports whether an offset falls on one of the result bytes.
  function automatic logic is_result(input logic [3:0] addr);
    is_result = (addr >= OFS_RESULT_BASE) && (addr <= OFS_RESULT_LAST);
  endfunction : is_result

  // Upper byte of the 16-bit view of a left-justified result.
  function automatic logic [7:0] upper_byte(input logic [RESULT_WIDTH-1:0] value);
    logic [15:0] word;
    word       = 16'(value) << RESULT_SHIFT;
    upper_byte = word[15:8];
  endfunction : upper_byte

  // Lower byte of the 16-bit view; the six low bits are always zero.
  function automatic logic [7:0] lower_byte(input logic [RESULT_WIDTH-1:0] value);
    logic [15:0] word;
    word       = 16'(value) << RESULT_SHIFT;
    lower_byte = word[7:0];
  endfunction : lower_byte

  // ****************************************************************
  // External trigger synchroniser
  // ****************************************************************
  // The pin level is accepted only once the second and third stages agree.
  always_comb begin
    nxt_ext_level = ext_level_ff;
    if (ext_s2_ff == ext_s3_ff) begin
      nxt_ext_level = ext_s3_ff;
    end
  end

  assign ext_fall = ext_level_ff && !nxt_ext_level;

  // Three sampling stages plus the accepted level; pin idles high.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_s1_ff    <= 1'b1;
      ext_s2_ff    <= 1'b1;
      ext_s3_ff    <= 1'b1;
      ext_level_ff <= 1'b1;
    end else begin
      ext_s1_ff    <= external_trigger_pin_b;
      ext_s2_ff    <= ext_s1_ff;
      ext_s3_ff    <= ext_s2_ff;
      ext_level_ff <= nxt_ext_level;
    end
  end

  // ****************************************************************
  // Conversion sequencer
  // ****************************************************************
  // Launches the engine per channel and files each answer in its register.
  always_comb begin
    nxt_seq        = seq_ff;
    nxt_cur        = cur_ff;
    nxt_channel    = channel_ff;
    nxt_eng_start  = 1'b0;
    nxt_result     = result_ff;
    seq_single_end = 1'b0;
    seq_pass_end   = 1'b0;
    eng_abort      = 1'b0;
    case (seq_ff)
      SEQ_IDLE: begin
        if (start_ff && !module_stop_ff) begin
          nxt_cur = scan_ff ? 2'b00 : index_ff;
          nxt_seq = SEQ_LAUNCH;
        end
      end
      SEQ_LAUNCH: begin
        nxt_channel   = {set_select_ff, group_select_ff, cur_ff};
        nxt_eng_start = 1'b1;
        nxt_seq       = SEQ_RUN;
      end
      SEQ_RUN: begin
        if (eng_done) begin
          nxt_result[cur_ff] = eng_result;
          if (!scan_ff) begin
            seq_single_end = 1'b1;
            nxt_seq        = SEQ_IDLE;
          end else begin
            seq_pass_end = (cur_ff == index_ff);
            nxt_cur      = seq_pass_end ? 2'b00 : cur_ff + 2'b01;
            nxt_seq      = SEQ_LAUNCH;
          end
        end
      end
      default: nxt_seq = SEQ_IDLE;
    endcase
    if ((seq_ff != SEQ_IDLE) && (!start_ff || module_stop_ff)) begin
      eng_abort     = 1'b1;
      nxt_eng_start = 1'b0;
      nxt_seq       = SEQ_IDLE;
    end
  end

  // Sequencer registers and stored results.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      seq_ff       <= SEQ_IDLE;
      cur_ff       <= 2'b00;
      channel_ff   <= 4'h0;
      eng_start_ff <= 1'b0;
      for (int i = 0; i < RESULT_COUNT; i++) begin
        result_ff[i] <= RESULT_RESET;
      end
    end else begin
      seq_ff       <= nxt_seq;
      cur_ff       <= nxt_cur;
      channel_ff   <= nxt_channel;
      eng_start_ff <= nxt_eng_start;
      result_ff    <= nxt_result;
    end
  end

  // Approximation engine working on the selected input.
  sar_engine #(
    .WIDTH         (RESULT_WIDTH),
    .SAMPLE_CYCLES (SAMPLE_CYCLES),
    .BIT_CYCLES    (BIT_CYCLES)
  ) engine (
    .clk             (clk),
    .rst_b           (rst_b),
    .start           (eng_start_ff),
    .abort           (eng_abort),
    .comparator_high (comparator_high),
    .sample_hold     (sample_hold),
    .dac_code        (dac_code),
    .done            (eng_done),
    .result          (eng_result)
  );

  // ****************************************************************
  // Register bus
  // ****************************************************************
  assign status_byte  = {end_flag_ff, irq_enable_ff, start_ff, scan_ff,
                         set_select_ff, group_select_ff, index_ff};
  assign control_byte = {module_stop_ff, 5'b00000, timer_en_ff, ext_en_ff};

  // Reads, writes, triggers and hardware updates of the control bits.
  always_comb begin
    nxt_end_flag     = end_flag_ff;
    nxt_flag_seen    = flag_seen_ff;
    nxt_irq_enable   = irq_enable_ff;
    nxt_start        = start_ff;
    nxt_scan         = scan_ff;
    nxt_set_select   = set_select_ff;
    nxt_group_select = group_select_ff;
    nxt_index        = index_ff;
    nxt_module_stop  = module_stop_ff;
    nxt_timer_en     = timer_en_ff;
    nxt_ext_en       = ext_en_ff;
    nxt_temp         = temp_ff;
    nxt_rdata        = rdata_ff;
    if (seq_single_end) begin
      nxt_start = 1'b0;
    end
    if (bus_rd) begin
      if (is_result(bus_addr) && !bus_addr[0]) begin
        nxt_rdata = upper_byte(result_ff[bus_addr[2:1]]);
        nxt_temp  = lower_byte(result_ff[bus_addr[2:1]]);
      end else if (is_result(bus_addr)) begin
        nxt_rdata = temp_ff;
      end else if (bus_addr == OFS_CONTROL_STATUS) begin
        nxt_rdata = status_byte;
        if (end_flag_ff) begin
          nxt_flag_seen = 1'b1;
        end
      end else if (bus_addr == OFS_CONTROL) begin
        nxt_rdata = control_byte;
      end else begin
        nxt_rdata = 8'h00;
      end
    end
    if (bus_wr && (bus_addr == OFS_CONTROL_STATUS)) begin
      if (!bus_wdata[BIT_END_FLAG] && flag_seen_ff) begin
        nxt_end_flag  = 1'b0;
        nxt_flag_seen = 1'b0;
      end
      nxt_irq_enable   = bus_wdata[BIT_IRQ_ENABLE];
      nxt_start        = bus_wdata[BIT_START] && !module_stop_ff;
      nxt_scan         = bus_wdata[BIT_SCAN];
      nxt_set_select   = bus_wdata[BIT_SET_SELECT];
      nxt_group_select = bus_wdata[BIT_GROUP_SEL];
      nxt_index        = bus_wdata[BIT_INDEX_HI:BIT_INDEX_LO];
    end else if (bus_wr && (bus_addr == OFS_CONTROL)) begin
      nxt_module_stop = bus_wdata[BIT_MODULE_STOP];
      nxt_timer_en    = bus_wdata[BIT_TIMER_EN];
      nxt_ext_en      = bus_wdata[BIT_EXT_EN];
    end
    if (!module_stop_ff && ((timer_en_ff && timer_trigger) || (ext_en_ff && ext_fall))) begin
      nxt_start = 1'b1;
    end
    if (nxt_module_stop) begin
      nxt_start = 1'b0;
    end
    if (seq_single_end || seq_pass_end) begin
      nxt_end_flag = 1'b1;
    end
  end

  assign nxt_irq = nxt_end_flag && nxt_irq_enable;

  // Control, status, holding latch and read data registers.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      end_flag_ff     <= CONTROL_STATUS_RESET[BIT_END_FLAG];
      flag_seen_ff    <= 1'b0;
      irq_enable_ff   <= CONTROL_STATUS_RESET[BIT_IRQ_ENABLE];
      start_ff        <= CONTROL_STATUS_RESET[BIT_START];
      scan_ff         <= CONTROL_STATUS_RESET[BIT_SCAN];
      set_select_ff   <= CONTROL_STATUS_RESET[BIT_SET_SELECT];
      group_select_ff <= CONTROL_STATUS_RESET[BIT_GROUP_SEL];
      index_ff        <= CONTROL_STATUS_RESET[BIT_INDEX_HI:BIT_INDEX_LO];
      module_stop_ff  <= CONTROL_RESET[BIT_MODULE_STOP];
      timer_en_ff     <= CONTROL_RESET[BIT_TIMER_EN];
      ext_en_ff       <= CONTROL_RESET[BIT_EXT_EN];
      temp_ff         <= 8'h00;
      rdata_ff        <= 8'h00;
      irq_ff          <= 1'b0;
    end else begin
      end_flag_ff     <= nxt_end_flag;
      flag_seen_ff    <= nxt_flag_seen;
      irq_enable_ff   <= nxt_irq_enable;
      start_ff        <= nxt_start;
      scan_ff         <= nxt_scan;
      set_select_ff   <= nxt_set_select;
      group_select_ff <= nxt_group_select;
      index_ff        <= nxt_index;
      module_stop_ff  <= nxt_module_stop;
      timer_en_ff     <= nxt_timer_en;
      ext_en_ff       <= nxt_ext_en;
      temp_ff         <= nxt_temp;
      rdata_ff        <= nxt_rdata;
      irq_ff          <= nxt_irq;
    end
  end

  assign bus_rdata          = rdata_ff;
  assign analog_channel     = channel_ff;
  assign conversion_end_irq = irq_ff;

endmodule : adc_channel_result_control
`default_nettype wire

// >>> dv/analog_front_model.sv
// Analog front end model: held input level and comparator.
`timescale 1ns/1ns
`default_nettype none
module analog_front_model
  import adc_ctrl_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [3:0] analog_channel,
  input  wire logic       sample_hold,
  input  wire logic [9:0] dac_code,
  output var  logic       comparator_high
);
  logic [9:0] held_ff;
  // The hold capacitor tracks the selected input while sampling.
  // sixteen inputs
  always_ff @(posedge clk) begin
    if (sample_hold) begin
      held_ff <= {analog_channel, analog_channel[1:0], ~analog_channel};
    end
  end
  // Level sits half a step above the held code, so no trial ever ties.
  assign comparator_high = (dac_code <= held_ff);
endmodule : analog_front_model
`default_nettype wire

// >>> dv/adc_channel_result_control_chk.sv
// Checker for the converter control block ports.
`timescale 1ns/1ns
`default_nettype none
module adc_channel_result_control_chk #(
  parameter int SAMPLE_CYCLES = 10
) (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic [3:0] bus_addr,
  input wire logic       bus_wr,
  input wire logic       bus_rd,
  input wire logic [7:0] bus_rdata,
  input wire logic [3:0] analog_channel,
  input wire logic       sample_hold,
  input wire logic       conversion_end_irq
);
  int hold_cnt_ff;
  int nxt_hold_cnt;
  // Counts the cycles of the current sampling phase.
  always_comb begin
    nxt_hold_cnt = sample_hold ? hold_cnt_ff + 1 : 0;
  end
  // Registers the sampling counter.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_cnt_ff <= 0;
    end else begin
      hold_cnt_ff <= nxt_hold_cnt;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Port relations of the register bus, sampling and interrupt.
  property p_rdata_hold; !$past(bus_rd) |-> $stable(bus_rdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_unmapped; bus_rd && bus_addr > 4'h9 |=> bus_rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_lo_zero; bus_rd && !bus_addr[3] && bus_addr[0] |=> bus_rdata[5:0] == 6'h00;
  endproperty
  a_lo_zero: assert property (p_lo_zero) else $error("low bits not zero");
  property p_ctrl_zero; bus_rd && bus_addr == 4'h9 |=> bus_rdata[6:2] == 5'h00; endproperty
  a_ctrl_zero: assert property (p_ctrl_zero) else $error("control spare bits set");
  property p_sample_len;
    $fell(sample_hold) && !$past(bus_wr) && !$past(bus_wr, 2) |-> hold_cnt_ff == SAMPLE_CYCLES;
  endproperty
  a_sample_len: assert property (p_sample_len) else $error("sampling length wrong");
  property p_chan_stable; sample_hold && $past(sample_hold) |-> $stable(analog_channel);
  endproperty
  a_chan_stable: assert property (p_chan_stable) else $error("channel moved");
  property p_irq_fall; $fell(conversion_end_irq) |-> $past(bus_wr); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell alone");
  property p_irq_rise;
    $rose(conversion_end_irq) && !$past(bus_wr) |-> !sample_hold && !$past(sample_hold);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose while sampling");
  c_sample: cover property ($fell(sample_hold));
  c_irq: cover property ($rose(conversion_end_irq));
  c_lo: cover property (bus_rd && bus_addr == 4'h7);
endmodule : adc_channel_result_control_chk
`default_nettype wire

// >>> dv/adc_channel_result_control_bench.sv
// Bench for the converter control block: register tasks and directed tests.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module adc_channel_result_control_bench;
  import adc_ctrl_pkg::*;
  logic       clk = 0, rst_b = 0, bus_wr = 0, bus_rd = 0, timer_trigger = 0;
  logic       external_trigger_pin_b = 1, comparator_high, sample_hold, conversion_end_irq;
  logic [3:0] bus_addr = 0, analog_channel;
  logic [7:0] bus_wdata = 0, bus_rdata, d = 0;
  logic [9:0] dac_code;
  int         mismatches = 0, comparisons = 0, cycles = 0;
  adc_channel_result_control #(.SAMPLE_CYCLES(2), .BIT_CYCLES(1)) DUT (.clk(clk),
    .rst_b(rst_b), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .timer_trigger(timer_trigger),
    .external_trigger_pin_b(external_trigger_pin_b), .comparator_high(comparator_high),
    .analog_channel(analog_channel), .sample_hold(sample_hold), .dac_code(dac_code),
    .conversion_end_irq(conversion_end_irq));
  analog_front_model FE (.clk(clk), .analog_channel(analog_channel),
    .sample_hold(sample_hold), .dac_code(dac_code), .comparator_high(comparator_high));
  // Clock and hang guard.
  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      end_sim();
    end
  end
  // Input level that the front model presents for a channel.
  function automatic logic [9:0] lev(input logic [3:0] c);
    return {c, c[1:0], ~c};
  endfunction : lev
  // Byte read: the strobe stands over one rising edge, and the data is taken at the next falling edge.
  task automatic rd(input logic [3:0] a);
    @(negedge clk);
    bus_addr = a;
    bus_rd = 1'b1;
    @(negedge clk);
    bus_rd = 1'b0;
    d = bus_rdata;
  endtask : rd
  // Byte write: address, data and strobe stand over one rising edge.
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(negedge clk);
    bus_addr = a;
    bus_wdata = v;
    bus_wr = 1'b1;
    @(negedge clk);
    bus_wr = 1'b0;
  endtask : wr
  // Polls the status until the end flag reads high, which arms its clearing.
  task automatic wait_end;
    d = 8'h00;
    for (int i = 0; i < 100 && !d[7]; i++) begin
      rd(4'h8);
    end
    `CHK(d[7], 1'b1)
  endtask : wait_end
  // Reads a result register as a word and compares both bytes.
  task automatic chk_res(input int r, input logic [3:0] c);
    logic [9:0] v;
    v = lev(c);
    rd(4'(2 * r));
    `CHK(d, v[9:2])
    rd(4'(2 * r + 1));
    `CHK(d, {v[1:0], 6'h00})
  endtask : chk_res
  // Prints the counts and the verdict, then ends the run.
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim
  // Main sequence of directed tests.
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk) rst_b = 1'b1;
    rd(4'h8);
    `CHK(d, CONTROL_STATUS_RESET)
    rd(4'h9);
    `CHK(d, CONTROL_RESET)
    rd(4'h0);
    `CHK(d, 8'h00)
    rd(4'hA);
    `CHK(d, 8'h00)
    for (int c = 0; c < 16; c++) begin
      wr(4'h8, 8'h20 | 8'(c));
      wait_end();
      `CHK(d[5], 1'b0)
      `CHK(conversion_end_irq, 1'b0)
      wr(4'h8, 8'h00);
      chk_res(c % 4, 4'(c));
    end
    rd(4'h8);
    `CHK(d, 8'h00)
    wr(4'h0, 8'hFF);
    wr(4'h1, 8'hFF);
    chk_res(0, 4'hC);
    rd(4'h0);
    rd(4'h6);
    rd(4'h7);
    `CHK(d, 8'h00)
    wr(4'h8, 8'h76);
    wait_end();
    `CHK(d[5], 1'b1)
    `CHK(conversion_end_irq, 1'b1)
    wr(4'h8, 8'h00);
    `CHK(conversion_end_irq, 1'b0)
    chk_res(0, 4'h4);
    chk_res(1, 4'h5);
    chk_res(2, 4'h6);
    chk_res(3, 4'hF);
    wr(4'h9, 8'h03);
    wr(4'h8, 8'h01);
    @(negedge clk) timer_trigger = 1'b1;
    @(negedge clk) timer_trigger = 1'b0;
    wait_end();
    wr(4'h8, 8'h0A);
    chk_res(1, 4'h1);
    @(negedge clk) external_trigger_pin_b = 1'b0;
    repeat (3) @(negedge clk);
    external_trigger_pin_b = 1'b1;
    wait_end();
    wr(4'h8, 8'h00);
    chk_res(2, 4'hA);
    wr(4'h9, 8'h80);
    wr(4'h8, 8'h23);
    rd(4'h8);
    `CHK(d[5], 1'b0)
    rd(4'h9);
    `CHK(d, 8'h80)
    wr(4'h9, 8'h00);
    wr(4'h8, 8'h23);
    wait_end();
    wr(4'h8, 8'h00);
    chk_res(3, 4'h3);
    end_sim();
  end
endmodule : adc_channel_result_control_bench
bind adc_channel_result_control adc_channel_result_control_chk #(
  .SAMPLE_CYCLES(SAMPLE_CYCLES)) u_chk (.clk(clk), .rst_b(rst_b), .bus_addr(bus_addr),
  .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .analog_channel(analog_channel),
  .sample_hold(sample_hold), .conversion_end_irq(conversion_end_irq));
`default_nettype wire
